// >>> include/flash_writer_map.vh
// Register map, field positions, reset values and timing for the flash block writer
`ifndef FLASH_WRITER_MAP_VH
`define FLASH_WRITER_MAP_VH

// Register indices; the byte address on the bus is four times the index
`define NV_EVENT_FLAGS_IDX    10'h00d
`define NV_EVENT_ENABLES_IDX  10'h08d
`define NV_DATA_LOW_IDX       10'h10c
`define NV_ADDRESS_LOW_IDX    10'h10d
`define NV_DATA_HIGH_IDX      10'h10e
`define NV_ADDRESS_HIGH_IDX   10'h10f
`define NV_CONTROL_IDX        10'h18c
`define NV_UNLOCK_PORT_IDX    10'h18d
`define NV_CONFIG_STATUS_IDX  10'h190

// nv_control fields
`define CTL_PGD_BIT           7
`define CTL_FREE_BIT          4
`define CTL_WRITE_ERROR_FLAG_BIT         3
`define CTL_WRITE_ENABLE_BIT          2
`define CTL_WR_BIT            1
`define CTL_RD_BIT            0

// nv_event_flags / nv_event_enables field
`define EVT_DONE_BIT          4

// nv_config_status fields
`define CFG_WPR_LSB           0
`define CFG_CP_PROG_BIT       2
`define CFG_CP_DATA_BIT       3
`define CFG_PWRT_DONE_BIT     4
`define CFG_BUSY_BIT          5

// Reset values
`define CTL_RESET             8'h00
`define EVT_RESET             8'h00
`define REG_RESET             8'h00
`define BUF_RESET             14'h3fff

// Unlock keys
`define UNLOCK_KEY_FIRST      8'h55
`define UNLOCK_KEY_SECOND     8'haa

// Write-protect region lower-segment limits (addresses below are protected)
`define WP_LIMIT_CODE10       13'h0100
`define WP_LIMIT_CODE01       13'h0800
`define WP_LIMIT_CODE00       13'h1000

// Timing
`define CLK_MHZ               50
`define PROG_TIME_US          2000
`define PWRT_TIME_US          72000

`endif

// >>> src/sync_agree.v
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module sync_agree #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] level_q
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q    <= {WIDTH{1'b0}};
      s2_q    <= {WIDTH{1'b0}};
      s3_q    <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
    end else begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end
  end
endmodule

// >>> src/flash_block_writer.v
// Flash program memory block writer with APB register file
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "flash_writer_map.vh"
module flash_block_writer #(
  parameter PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ,
  parameter PWRT_CYCLES = `PWRT_TIME_US * `CLK_MHZ
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        instr_retire,
  input  wire [1:0]  write_protect_region,
  input  wire        cp_prog_on,
  input  wire        cp_data_on,
  input  wire        ext_prog_read_req,
  input  wire        ext_prog_write_req,
  input  wire        ext_data_read_req,
  input  wire        ext_data_write_req,
  output reg         cpu_stall_q,
  output reg         instr_squash_q,
  output reg         flash_prog_q,
  output reg  [10:0] flash_block_addr_q,
  output reg  [55:0] flash_block_data_q,
  output reg         ext_prog_read_grant_q,
  output reg         ext_prog_write_grant_q,
  output reg         ext_data_read_grant_q,
  output reg         ext_data_write_grant_q
);
  localparam ST_IDLE   = 2'd0;
  localparam ST_EXEC   = 2'd1;
  localparam ST_SQUASH = 2'd2;
  localparam ST_PROG   = 2'd3;

  localparam UL_IDLE   = 2'd0;
  localparam UL_FIRST  = 2'd1;
  localparam UL_ARMED  = 2'd2;

  localparam [21:0] PROG_LAST = PROG_CYCLES - 1;
  localparam [21:0] PWRT_LAST = PWRT_CYCLES - 1;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [1:0]  unlock_q;
  reg  [21:0] prog_cnt_q;
  reg  [21:0] pwrt_cnt_q;
  reg         pwrt_done_q;
  reg  [7:0]  data_low_q;
  reg  [7:0]  addr_low_q;
  reg  [5:0]  data_high_q;
  reg  [4:0]  addr_high_q;
  reg         pgd_q;
  reg         free_q;
  reg         write_error_flag_q;
  reg         write_enable_q;
  reg         wr_q;
  reg         done_flag_q;
  reg         done_en_q;
  reg  [13:0] buf_q [0:3];

  wire [1:0] cfg_wpr;
  wire       cfg_cp_prog;
  wire       cfg_cp_data;
  wire [3:0] ext_req;

  // Configuration bits and external requests arrive from outside the clock domain
  sync_agree #(
    .WIDTH (8)
  ) u_pin_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin     ({ext_data_write_req, ext_data_read_req, ext_prog_write_req,
                ext_prog_read_req, cp_data_on, cp_prog_on, write_protect_region}),
    .level_q ({ext_req, cfg_cp_data, cfg_cp_prog, cfg_wpr})
  );

  wire [9:0]  idx      = paddr[11:2];
  wire        aligned  = (paddr[1:0] == 2'b00);
  wire        acc      = psel & penable & pready;
  wire        wr_acc   = acc & pwrite & ~pslverr;
  wire [12:0] tgt_addr = {addr_high_q, addr_low_q};
  wire [13:0] tgt_word = {data_high_q, data_low_q};
  wire        busy     = (state_q != ST_IDLE);

  wire hit_flags = (idx == `NV_EVENT_FLAGS_IDX);
  wire hit_ens   = (idx == `NV_EVENT_ENABLES_IDX);
  wire hit_dl    = (idx == `NV_DATA_LOW_IDX);
  wire hit_al    = (idx == `NV_ADDRESS_LOW_IDX);
  wire hit_dh    = (idx == `NV_DATA_HIGH_IDX);
  wire hit_ah    = (idx == `NV_ADDRESS_HIGH_IDX);
  wire hit_ctl   = (idx == `NV_CONTROL_IDX);
  wire hit_ul    = (idx == `NV_UNLOCK_PORT_IDX);
  wire hit_cfg   = (idx == `NV_CONFIG_STATUS_IDX);
  wire mapped    = aligned & (hit_flags | hit_ens | hit_dl | hit_al | hit_dh |
                              hit_ah | hit_ctl | hit_ul | hit_cfg);

  reg protected_seg;
  always @* begin
    case (cfg_wpr)
      2'b10:   protected_seg = (tgt_addr < `WP_LIMIT_CODE10);
      2'b01:   protected_seg = (tgt_addr < `WP_LIMIT_CODE01);
      2'b00:   protected_seg = (tgt_addr < `WP_LIMIT_CODE00);
      default: protected_seg = 1'b0;
    endcase
  end

  // Start request: software writes one to the start bit of the control register
  wire start_req = wr_acc & hit_ctl & pwdata[`CTL_WR_BIT] & ~wr_q & ~busy;
  // start without full unlock is dropped
  wire start_ok = start_req & write_enable_q & (unlock_q == UL_ARMED) & pwrt_done_q &
                  pgd_q & ~free_q & ~protected_seg;
  // short write when low bits are not 11
  wire short_wr = start_ok & (addr_low_q[1:0] != 2'b11);
  // long write when low bits are 11
  wire long_wr  = start_ok & (addr_low_q[1:0] == 2'b11);
  wire prog_end = (state_q == ST_PROG) & (prog_cnt_q == PROG_LAST);

  // APB slave: zero wait states, answer prepared in the setup cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite & mapped) begin
        prdata <= 32'h00000000;
        if (hit_flags) prdata[`EVT_DONE_BIT] <= done_flag_q;
        if (hit_ens) prdata[`EVT_DONE_BIT] <= done_en_q;
        if (hit_dl) prdata[7:0] <= data_low_q;
        if (hit_al) prdata[7:0] <= addr_low_q;
        if (hit_dh) prdata[5:0] <= data_high_q;
        if (hit_ah) prdata[4:0] <= addr_high_q;
        if (hit_ctl) begin
          prdata[`CTL_PGD_BIT]   <= pgd_q;
          prdata[`CTL_FREE_BIT]  <= free_q;
          prdata[`CTL_WRITE_ERROR_FLAG_BIT] <= write_error_flag_q;
          prdata[`CTL_WRITE_ENABLE_BIT]  <= write_enable_q;
          prdata[`CTL_WR_BIT]    <= wr_q;
        end
        if (hit_cfg) begin
          prdata[`CFG_WPR_LSB+1:`CFG_WPR_LSB] <= cfg_wpr;
          prdata[`CFG_CP_PROG_BIT]            <= cfg_cp_prog;
          prdata[`CFG_CP_DATA_BIT]            <= cfg_cp_data;
          prdata[`CFG_PWRT_DONE_BIT]          <= pwrt_done_q;
          prdata[`CFG_BUSY_BIT]               <= busy;
        end
      end
    end
  end

  // Data and address registers; software may change them while a block programs,
  // the block image is latched at start so this is harmless
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_low_q  <= `REG_RESET;
      addr_low_q  <= `REG_RESET;
      data_high_q <= 6'h00;
      addr_high_q <= 5'h00;
      done_en_q   <= 1'b0;
    end else if (wr_acc) begin
      if (hit_dl) data_low_q <= pwdata[7:0];
      if (hit_al) addr_low_q <= pwdata[7:0];
      if (hit_dh) data_high_q <= pwdata[5:0];
      if (hit_ah) addr_high_q <= pwdata[4:0];
      if (hit_ens) done_en_q <= pwdata[`EVT_DONE_BIT];
    end
  end

  // Control register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pgd_q   <= 1'b0;
      free_q  <= 1'b0;
      write_error_flag_q <= 1'b0;
      write_enable_q  <= 1'b0;
      wr_q    <= 1'b0;
    end else begin
      if (wr_acc & hit_ctl) begin
        pgd_q   <= pwdata[`CTL_PGD_BIT];
        free_q  <= pwdata[`CTL_FREE_BIT];
        write_error_flag_q <= pwdata[`CTL_WRITE_ERROR_FLAG_BIT];
        write_enable_q  <= pwdata[`CTL_WRITE_ENABLE_BIT];
      end
      // long write clears start bit at end
      if (start_ok)
        wr_q <= 1'b1;
      else if ((wr_q & ~busy) | prog_end)
        wr_q <= 1'b0;
    end
  end

  // Unlock sequencer: any other write in between breaks the sequence
  // 55 then AA, back to back
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= UL_IDLE;
    end else if (wr_acc) begin
      if (hit_ul & (pwdata[7:0] == `UNLOCK_KEY_FIRST))
        unlock_q <= UL_FIRST;
      else if (hit_ul & (unlock_q == UL_FIRST) & (pwdata[7:0] == `UNLOCK_KEY_SECOND))
        unlock_q <= UL_ARMED;
      else
        unlock_q <= UL_IDLE;
    end
  end

  // sticky done flag, set wins over clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      done_flag_q <= 1'b0;
    else if (prog_end)
      done_flag_q <= 1'b1;
    else if (wr_acc & hit_flags)
      done_flag_q <= pwdata[`EVT_DONE_BIT];
  end

  // four 14-bit buffers selected by low address bits
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_buf
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          buf_q[gi] <= `BUF_RESET;
        else if (prog_end)
          buf_q[gi] <= `BUF_RESET;
        // short and long write copy data in
        else if (start_ok & (addr_low_q[1:0] == gi))
          buf_q[gi] <= tgt_word;
      end
    end
  endgenerate

  // Power-up timer
  // 72 ms lockout count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrt_cnt_q  <= 22'd0;
      pwrt_done_q <= 1'b0;
    end else if (!pwrt_done_q) begin
      pwrt_cnt_q  <= pwrt_cnt_q + 22'd1;
      pwrt_done_q <= (pwrt_cnt_q == PWRT_LAST);
    end
  end

  // Sequencer for long writes
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (long_wr) state_d = ST_EXEC;
      ST_EXEC:   if (instr_retire) state_d = ST_SQUASH;
      ST_SQUASH: if (instr_retire) state_d = ST_PROG;
      ST_PROG:   if (prog_end) state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q            <= ST_IDLE;
      prog_cnt_q         <= 22'd0;
      cpu_stall_q        <= 1'b0;
      instr_squash_q     <= 1'b0;
      flash_prog_q       <= 1'b0;
      flash_block_addr_q <= 11'h000;
      flash_block_data_q <= 56'h00000000000000;
    end else begin
      state_q        <= state_d;
      instr_squash_q <= (state_d == ST_SQUASH);
      // stall for programming time, clocks run
      cpu_stall_q    <= (state_d == ST_PROG);
      flash_prog_q   <= (state_d == ST_PROG);
      if (state_q == ST_PROG)
        prog_cnt_q <= prog_cnt_q + 22'd1;
      else
        prog_cnt_q <= 22'd0;
      // aligned block address, low bits dropped
      // last word joins the three buffered words
      if (long_wr) begin
        flash_block_addr_q <= tgt_addr[12:2];
        flash_block_data_q <= {tgt_word, buf_q[2], buf_q[1], buf_q[0]};
      end
    end
  end

  // External programmer access gating
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prog_read_grant_q  <= 1'b0;
      ext_prog_write_grant_q <= 1'b0;
      ext_data_read_grant_q  <= 1'b0;
      ext_data_write_grant_q <= 1'b0;
    end else begin
      // program protect blocks external program access
      ext_prog_read_grant_q  <= ext_req[0] & ~cfg_cp_prog;
      // data protect also blocks external program writes
      ext_prog_write_grant_q <= ext_req[1] & ~cfg_cp_prog & ~cfg_cp_data;
      // data protect blocks external data access
      ext_data_read_grant_q  <= ext_req[2] & ~cfg_cp_data;
      ext_data_write_grant_q <= ext_req[3] & ~cfg_cp_data;
    end
  end
endmodule

// >>> tb/flash_block_writer_sva.sv
// Port assertions for the flash block writer
`timescale 1ns/1ps
module flash_block_writer_sva #(
  parameter PROG_CYCLES = 100000
) (
  input wire        clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        instr_retire,
  input wire        cp_prog_on,
  input wire        cp_data_on,
  input wire        cpu_stall_q,
  input wire        instr_squash_q,
  input wire        flash_prog_q,
  input wire [10:0] flash_block_addr_q,
  input wire [55:0] flash_block_data_q,
  input wire        ext_prog_read_grant_q,
  input wire        ext_prog_write_grant_q,
  input wire        ext_data_read_grant_q,
  input wire        ext_data_write_grant_q
);
  reg [31:0] run_q;
  reg [3:0]  cpd_q;
  reg [3:0]  cpp_q;
  // Protect counters saturate so the pin synchronisers have long settled
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 32'h0;
      cpd_q <= 4'h0;
      cpp_q <= 4'h0;
    end else begin
      run_q <= flash_prog_q ? run_q + 32'h1 : 32'h0;
      cpd_q <= !cp_data_on ? 4'h0 : ((cpd_q == 4'hf) ? cpd_q : cpd_q + 4'h1);
      cpp_q <= !cp_prog_on ? 4'h0 : ((cpp_q == 4'hf) ? cpp_q : cpp_q + 4'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_prog_length: assert property (
    $fell(flash_prog_q) |-> run_q == PROG_CYCLES) else $error("programming length wrong");
  a_prog_bound: assert property (
    flash_prog_q |-> run_q < PROG_CYCLES) else $error("programming too long");
  a_stall_tie: assert property (
    cpu_stall_q == flash_prog_q) else $error("stall differs from programming");
  a_squash_excl: assert property (
    instr_squash_q |-> !cpu_stall_q) else $error("squash during stall");
  a_squash_end: assert property (
    instr_squash_q && instr_retire |=> !instr_squash_q) else $error("squash too long");
  a_prog_follows: assert property (
    $fell(instr_squash_q) |-> ##[0:1] flash_prog_q) else $error("no stall after squash");
  a_block_hold: assert property (
    flash_prog_q && $past(flash_prog_q) |->
      $stable(flash_block_addr_q) && $stable(flash_block_data_q)) else $error("block moved");
  a_ready_access: assert property (
    pready == (psel && penable)) else $error("pready outside access");
  a_misalign_err: assert property (
    psel && penable && paddr[1:0] != 2'b00 |-> pslverr) else $error("misaligned accepted");
  a_data_protect: assert property (
    cpd_q == 4'hf |-> !ext_data_read_grant_q && !ext_data_write_grant_q
      && !ext_prog_write_grant_q) else $error("grant under data protect");
  a_prog_protect: assert property (
    cpp_q == 4'hf |-> !ext_prog_read_grant_q && !ext_prog_write_grant_q)
    else $error("grant under program protect");
endmodule
bind flash_block_writer flash_block_writer_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .instr_retire(instr_retire),
  .cp_prog_on(cp_prog_on), .cp_data_on(cp_data_on), .cpu_stall_q(cpu_stall_q),
  .instr_squash_q(instr_squash_q), .flash_prog_q(flash_prog_q),
  .flash_block_addr_q(flash_block_addr_q), .flash_block_data_q(flash_block_data_q),
  .ext_prog_read_grant_q(ext_prog_read_grant_q),
  .ext_prog_write_grant_q(ext_prog_write_grant_q),
  .ext_data_read_grant_q(ext_data_read_grant_q),
  .ext_data_write_grant_q(ext_data_write_grant_q));

// >>> tb/tb_flash_block_writer.sv
// Self-checking bench for the flash block writer
`timescale 1ns/1ps
`include "flash_writer_map.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_flash_block_writer;
  localparam PROG = 20;
  logic        clk, rst_n, psel, penable, pwrite, retire, cp_prog, cp_data;
  logic        pready, pslverr, err_v, stall, squash, prog;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [1:0]  wpr;
  logic [3:0]  req, grant;
  logic [10:0] baddr;
  logic [55:0] bdata;
  logic [13:0] wd [4];
  int          n_errors, cmp_count, n;
  flash_block_writer #(.PROG_CYCLES(PROG), .PWRT_CYCLES(40)) u_flash_block_writer (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_retire(retire), .write_protect_region(wpr), .cp_prog_on(cp_prog),
    .cp_data_on(cp_data), .ext_prog_read_req(req[0]), .ext_prog_write_req(req[1]),
    .ext_data_read_req(req[2]), .ext_data_write_req(req[3]), .cpu_stall_q(stall),
    .instr_squash_q(squash), .flash_prog_q(prog), .flash_block_addr_q(baddr),
    .flash_block_data_q(bdata), .ext_prog_read_grant_q(grant[0]),
    .ext_prog_write_grant_q(grant[1]), .ext_data_read_grant_q(grant[2]),
    .ext_data_write_grant_q(grant[3]));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // slots hold no-ops
  // One retired instruction slot every other cycle
  always @(posedge clk) retire <= ~retire;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask
  task automatic rchk(input string nm, input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    `CHK(nm, e, rd_v)
  endtask
  task automatic word(input logic [7:0] lo, input logic [13:0] d, input logic [7:0] k2);
    wr(`NV_ADDRESS_LOW_IDX, {24'h0, lo});
    wr(`NV_DATA_LOW_IDX, {24'h0, d[7:0]});
    wr(`NV_DATA_HIGH_IDX, {26'h0, d[13:8]});
    wr(`NV_UNLOCK_PORT_IDX, 32'h55);
    wr(`NV_UNLOCK_PORT_IDX, {24'h0, k2});
    wr(`NV_CONTROL_IDX, 32'h86);
  endtask
  // Waits a bounded span for programming, then checks block and length
  task automatic long_chk(input logic e, input logic [10:0] ad, input logic [55:0] dt);
    int sq;
    n = 0;
    sq = 0;
    while (prog !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
      if (squash === 1'b1) sq++;
    end
    `CHK("prog_start", e, prog)
    if (e) begin
      // One discarded slot spans two cycles with retire every other cycle
      `CHK("squash_len", 2, sq)
      `CHK("stall", 1'b1, stall)
      `CHK("block_addr", ad, baddr)
      `CHK("block_data", dt, bdata)
      n = 0;
      while (prog === 1'b1) begin
        @(posedge clk);
        n++;
      end
      `CHK("prog_len", PROG, n)
    end
  endtask
  task print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #120000;
    n_errors++;
    print_verdict;
  end
  initial begin
    {rst_n, psel, penable, pwrite, retire, cp_prog, cp_data} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    wpr = 2'b11;
    req = 4'h0;
    wd = '{14'h0123, 14'h1a5b, 14'h2c3d, 14'h3e4f};
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk("control", `NV_CONTROL_IDX, 32'h0);
    rchk("flags", `NV_EVENT_FLAGS_IDX, 32'h0);
    rchk("enables", `NV_EVENT_ENABLES_IDX, 32'h0);
    wr(`NV_CONTROL_IDX, 32'h84);
    word(8'h03, 14'h1111, 8'haa);
    long_chk(1'b0, 11'h0, 56'h0);
    rchk("status", `NV_CONFIG_STATUS_IDX, 32'h13);
    word(8'h03, 14'h1111, 8'h00);
    long_chk(1'b0, 11'h0, 56'h0);
    wr(`NV_CONTROL_IDX, 32'h80);
    word(8'h03, 14'h1111, 8'haa);
    long_chk(1'b0, 11'h0, 56'h0);
    // Erase select stored: program start is refused
    wr(`NV_CONTROL_IDX, 32'h94);
    word(8'h03, 14'h1111, 8'haa);
    long_chk(1'b0, 11'h0, 56'h0);
    wpr <= 2'b10;
    wr(`NV_CONTROL_IDX, 32'h84);
    word(8'h03, 14'h1111, 8'haa);
    long_chk(1'b0, 11'h0, 56'h0);
    wpr <= 2'b11;
    wr(`NV_ADDRESS_HIGH_IDX, 32'h01);
    wr(`NV_CONTROL_IDX, 32'h84);
    for (int i = 0; i < 3; i++) begin
      word(i[7:0], wd[i], 8'haa);
      rchk("start_clr", `NV_CONTROL_IDX, 32'h84);
    end
    word(8'h03, wd[3], 8'haa);
    long_chk(1'b1, 11'h040, {wd[3], wd[2], wd[1], wd[0]});
    rchk("done_flag", `NV_EVENT_FLAGS_IDX, 32'h10);
    rchk("ctl_end", `NV_CONTROL_IDX, 32'h84);
    wr(`NV_EVENT_FLAGS_IDX, 32'h0);
    rchk("flag_clr", `NV_EVENT_FLAGS_IDX, 32'h0);
    // Only the last word loaded: the rest must read back as erased
    word(8'h07, 14'h2abc, 8'haa);
    long_chk(1'b1, 11'h041, {14'h2abc, {3{14'h3fff}}});
    wr(`NV_EVENT_ENABLES_IDX, 32'h10);
    rchk("enables_rw", `NV_EVENT_ENABLES_IDX, 32'h10);
    wr(`NV_DATA_HIGH_IDX, 32'hff);
    rchk("data_high", `NV_DATA_HIGH_IDX, 32'h3f);
    apb(1'b0, 12'hffc, 32'h0);
    `CHK("unmapped_err", 1'b1, err_v)
    // Refused read leaves the last read data standing
    `CHK("unmapped_data", 32'h3f, rd_v)
    apb(1'b1, 12'h631, 32'h0);
    `CHK("misaligned_err", 1'b1, err_v)
    req <= 4'hf;
    for (int c = 0; c < 4; c++) begin
      cp_prog <= c[0];
      cp_data <= c[1];
      repeat (16) @(posedge clk);
      `CHK("grants", {~c[1], ~c[1], ~c[0] & ~c[1], ~c[0]}, grant)
    end
    print_verdict;
  end
endmodule
